// ---- pkg/smp_pkg.sv ----
// Shared constants, types and behaviour summary for the SPI master port.
//
// Contract
// - SPI runs only while sync mode selected.
// - Pin mode picks enable pin active level.
// - Three-pin mode ignores the enable pin.
// - Power-up clear sets soft reset bit.
// - Soft reset clears enables, errors; sets tx flag.
// - Character length is seven or eight bits.
// - Seven-bit receive data right-aligned, top zero.
// - Bit order select; reset means LSB first.
// - Transfer starts only from a buffer write.
// - Buffer moves to empty shifter, first bit out.
// - Input sampled on edge opposite to launch.
// - Full character copied out, rx flag set.
// - Tx flag set when buffer moves to shifter.
// - Master receives only while it transmits.
// - Output select makes fourth pin guard or select.
// - Master-inactive guard releases data and clock pins.
// - Master-inactive guard sets the conflict error.
// - Master-inactive guard resets state, aborts shifting.
// - Buffered character sends when guard releases.
// - Master drives data out and clock pins.
// - Output select drives automatic single slave select.
// - Bit clock is source clock over divisor; divisors below two act as two.
// - Buffer write clears the tx flag.
// - Receive buffer read clears the rx flag.
package smp_pkg;
    localparam int SMP_DATA_W = 8;
    localparam int SMP_DIV_W = 16;
    localparam int SMP_FIFO_DEPTH = 8;
    localparam int SMP_MSB_8 = 7;
    localparam int SMP_MSB_7 = 6;
    localparam logic [1:0] SMP_PINS_4_HIGH = 2'h1;
    localparam logic [1:0] SMP_PINS_4_LOW = 2'h2;
    localparam logic [2:0] SMP_LAST_BIT_8 = 3'h7;
    localparam logic [2:0] SMP_LAST_BIT_7 = 3'h6;
    localparam logic [2:0] SMP_BIT_FIRST = 3'h0;
    localparam logic [2:0] SMP_BIT_STEP = 3'h1;
    localparam logic [15:0] SMP_DIV_MIN = 16'h0002;
    localparam logic [15:0] SMP_DIV_ONE = 16'h0001;
    localparam logic [15:0] SMP_DIV_ZERO = 16'h0000;
    localparam logic SMP_SOFT_RESET_INIT = 1'h1;
    localparam logic SMP_TX_FLAG_INIT = 1'h1;
    typedef enum logic {SMP_ST_IDLE = 1'b0, SMP_ST_SHIFT = 1'b1} smp_state_type;
endpackage : smp_pkg

// ---- pkg/smp_tick_if.sv ----
// Interface between the transfer engine and the bit-rate divider.
`timescale 1ns/1ps
`default_nettype none
interface smp_tick_if;
    logic run;
    logic [smp_pkg::SMP_DIV_W-1:0] divisor;
    logic rise;
    logic fall;
    modport ctl (output run, output divisor, input rise, input fall);
    modport div (input run, input divisor, output rise, output fall);
endinterface : smp_tick_if
`default_nettype wire

// ---- verilog/smp_clkdiv.sv ----
// Bit-rate divider producing serial clock rise and fall enables.
`timescale 1ns/1ps
`default_nettype none
module smp_clkdiv (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    smp_tick_if.div tick
);
    import smp_pkg::*;
    logic [SMP_DIV_W-1:0] cnt_ff;
    logic high_ff;
    // Divisors below two cannot toggle a flop-driven pin, so they run at half rate.
    wire [SMP_DIV_W-1:0] period = (tick.divisor < SMP_DIV_MIN) ? SMP_DIV_MIN : tick.divisor;
    wire [SMP_DIV_W-1:0] low_len = period >> 1;
    // Odd divisors give the extra cycle to the high phase.
    wire [SMP_DIV_W-1:0] high_len = period - low_len;
    wire [SMP_DIV_W-1:0] phase_len = high_ff ? high_len : low_len;
    wire phase_end = tick.run && (cnt_ff == phase_len - SMP_DIV_ONE);
    wire [SMP_DIV_W-1:0] nxt_cnt = (!tick.run || phase_end) ? SMP_DIV_ZERO : cnt_ff + SMP_DIV_ONE;
    wire nxt_high = tick.run && (phase_end ? !high_ff : high_ff);
    assign tick.rise = phase_end && !high_ff;
    assign tick.fall = phase_end && high_ff;
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cnt_ff <= SMP_DIV_ZERO;
            high_ff <= 1'h0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            high_ff <= nxt_high;
        end
    end
endmodule : smp_clkdiv
`default_nettype wire

// ---- verilog/smp_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module smp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    typedef logic [AW:0] smp_cnt_type;
    typedef logic [AW-1:0] smp_ptr_type;
    localparam smp_cnt_type FULL_CNT = smp_cnt_type'(DEPTH);
    localparam smp_cnt_type ZERO_CNT = smp_cnt_type'(0);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    smp_ptr_type wr_ff;
    smp_ptr_type rd_ff;
    smp_cnt_type cnt_ff;
    // Ready and valid are registered so that the top drives them from flops.
    wire push = in_valid_i && in_ready_o;
    wire pop = out_ready_i && out_valid_o;
    wire [AW:0] nxt_cnt = cnt_ff + smp_cnt_type'(push) - smp_cnt_type'(pop);
    assign out_data_o = mem_ff[rd_ff];
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_ff[wr_ff] <= in_data_i;
    end
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || flush_i)
        begin
            wr_ff <= smp_ptr_type'(0);
            rd_ff <= smp_ptr_type'(0);
            cnt_ff <= ZERO_CNT;
            in_ready_o <= 1'h0;
            out_valid_o <= 1'h0;
        end
        else
        begin
            wr_ff <= wr_ff + smp_ptr_type'(push);
            rd_ff <= rd_ff + smp_ptr_type'(pop);
            cnt_ff <= nxt_cnt;
            in_ready_o <= (nxt_cnt != FULL_CNT);
            out_valid_o <= (nxt_cnt != ZERO_CNT);
        end
    end
endmodule : smp_fifo
`default_nettype wire

// ---- verilog/spi_master_port.sv ----
// SPI master port: transmit path, shifters, flags, pin control and guard.
`timescale 1ns/1ps
`default_nettype none
module spi_master_port (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic soft_reset_set_i,
    input wire logic soft_reset_clr_i,
    output logic soft_reset_o,
    input wire logic sync_mode_select_i,
    input wire logic [1:0] pin_mode_field_i,
    input wire logic enable_pin_output_select_i,
    input wire logic seven_bit_select_i,
    input wire logic bit_order_select_i,
    input wire logic [smp_pkg::SMP_DIV_W-1:0] bit_rate_divisor_i,
    input wire logic irq_enable_wr_i,
    input wire logic rx_irq_enable_i,
    input wire logic tx_irq_enable_i,
    output logic rx_irq_enable_o,
    output logic tx_irq_enable_o,
    input wire logic tx_valid_i,
    input wire logic [smp_pkg::SMP_DATA_W-1:0] tx_data_i,
    output logic tx_ready_o,
    input wire logic rx_read_i,
    output logic [smp_pkg::SMP_DATA_W-1:0] rx_data_o,
    output logic rx_flag_o,
    output logic tx_flag_o,
    output logic overrun_error_o,
    output logic conflict_error_o,
    input wire logic error_clear_i,
    output logic busy_o,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_o,
    output logic peripheral_in_line_o,
    output logic peripheral_in_line_oe_o,
    input wire logic peripheral_out_line_i,
    input wire logic enable_pin_i,
    output logic enable_pin_o,
    output logic enable_pin_oe_o
);
    import smp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations and input synchronisers.

    smp_state_type state_ff;
    logic soft_reset_ff;
    logic ste_meta_ff;
    logic ste_ff;
    logic pout_meta_ff;
    logic pout_ff;
    logic [SMP_DATA_W-1:0] txbuf_ff;
    logic [SMP_DATA_W-1:0] txsh_ff;
    logic [SMP_DATA_W-1:0] rxsh_ff;
    logic [2:0] bitcnt_ff;
    logic fifo_valid;
    logic [SMP_DATA_W-1:0] fifo_data;

    smp_tick_if tick ();

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ste_meta_ff <= 1'h0;
            ste_ff <= 1'h0;
            pout_meta_ff <= 1'h0;
            pout_ff <= 1'h0;
        end
        else
        begin
            ste_meta_ff <= enable_pin_i;
            ste_ff <= ste_meta_ff;
            pout_meta_ff <= peripheral_out_line_i;
            pout_ff <= pout_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode and the multi-master guard.

    wire active = sync_mode_select_i && !soft_reset_ff;
    wire mode_high = (pin_mode_field_i == SMP_PINS_4_HIGH);
    wire mode_low = (pin_mode_field_i == SMP_PINS_4_LOW);
    // Any other pin mode counts as three-pin, so the enable pin is never looked at.
    wire four_pin = mode_high || mode_low;
    wire ste_master_off = mode_high ? ste_ff : !ste_ff;
    wire guard = active && four_pin && !enable_pin_output_select_i && ste_master_off;
    wire shifting = (state_ff == SMP_ST_SHIFT);
    wire msb_first = bit_order_select_i;
    wire [2:0] last_bit = seven_bit_select_i ? SMP_LAST_BIT_7 : SMP_LAST_BIT_8;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer fed by the FIFO, and the hand-off to the shifter.

    // The FIFO drains only into an empty transmit buffer, so a stalled link fills it.
    wire fifo_take = active && tx_flag_o;
    wire buf_write = fifo_take && fifo_valid;
    // A character held during the guard stays buffered and starts once released.
    wire start = active && !guard && !shifting && !tx_flag_o;
    wire sample = shifting && !guard && tick.rise;
    wire launch = shifting && !guard && tick.fall;
    wire done = launch && (bitcnt_ff == last_bit);

    smp_fifo #(
        .WIDTH(SMP_DATA_W),
        .DEPTH(SMP_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .flush_i(soft_reset_ff),
        .in_valid_i(tx_valid_i),
        .in_data_i(tx_data_i),
        .in_ready_o(tx_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(fifo_take)
    );

    assign tick.run = shifting;
    assign tick.divisor = bit_rate_divisor_i;

    smp_clkdiv u_div (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Shift registers and character alignment.

    wire [SMP_DATA_W-1:0] shifted = msb_first ? (txsh_ff << 1) : (txsh_ff >> 1);
    wire [SMP_DATA_W-1:0] nxt_txsh = start ? txbuf_ff : (launch ? shifted : txsh_ff);
    wire lead_msb = seven_bit_select_i ? nxt_txsh[SMP_MSB_7] : nxt_txsh[SMP_MSB_8];
    wire nxt_pin_data = msb_first ? lead_msb : nxt_txsh[0];
    wire [SMP_DATA_W-1:0] rx_in_msb = {rxsh_ff[SMP_DATA_W-2:0], pout_ff};
    wire [SMP_DATA_W-1:0] rx_in_lsb = {pout_ff, rxsh_ff[SMP_DATA_W-1:1]};
    wire [SMP_DATA_W-1:0] nxt_rxsh = msb_first ? rx_in_msb : rx_in_lsb;
    wire [SMP_DATA_W-2:0] rx_seven = msb_first ? rxsh_ff[SMP_DATA_W-2:0] : rxsh_ff[SMP_DATA_W-1:1];
    wire [SMP_DATA_W-1:0] rx_char = seven_bit_select_i ? {1'h0, rx_seven} : rxsh_ff;
    wire [2:0] nxt_bitcnt = start ? SMP_BIT_FIRST : launch ? bitcnt_ff + SMP_BIT_STEP : bitcnt_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state decode.

    // The guard wins over every other event and drops the shift in progress.
    wire go_idle = !active || guard || done;
    wire smp_state_type nxt_state = go_idle ? SMP_ST_IDLE : (start ? SMP_ST_SHIFT : state_ff);
    wire nxt_shifting = (nxt_state == SMP_ST_SHIFT);
    wire nxt_sclk = nxt_shifting && (tick.rise || (serial_clock_pin_o && !tick.fall));
    wire drive = active && !guard;
    wire slave_on_level = mode_high;
    wire nxt_select = nxt_shifting ? slave_on_level : !slave_on_level;
    wire nxt_soft_reset = soft_reset_set_i || (soft_reset_ff && !soft_reset_clr_i);
    // A completed character always wins over a read in the same cycle.
    wire nxt_rx_flag = done || (rx_flag_o && !rx_read_i);
    wire nxt_overrun = (done && rx_flag_o && !rx_read_i) || (overrun_error_o && !error_clear_i);
    wire nxt_conflict = guard || (conflict_error_o && !error_clear_i);
    wire nxt_tx_flag = start || (tx_flag_o && !buf_write);

    ////////////////////////////////////////////////////////////////////////////
    // Soft reset and software-visible flags.

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            soft_reset_ff <= SMP_SOFT_RESET_INIT;
        else
            soft_reset_ff <= nxt_soft_reset;
    end

    assign soft_reset_o = soft_reset_ff;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || soft_reset_ff)
        begin
            rx_flag_o <= 1'h0;
            tx_flag_o <= SMP_TX_FLAG_INIT;
            overrun_error_o <= 1'h0;
            conflict_error_o <= 1'h0;
            rx_irq_enable_o <= 1'h0;
            tx_irq_enable_o <= 1'h0;
        end
        else
        begin
            rx_flag_o <= nxt_rx_flag;
            tx_flag_o <= nxt_tx_flag;
            overrun_error_o <= nxt_overrun;
            conflict_error_o <= nxt_conflict;
            if (irq_enable_wr_i)
            begin
                rx_irq_enable_o <= rx_irq_enable_i;
                tx_irq_enable_o <= tx_irq_enable_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer engine.

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_ff <= SMP_ST_IDLE;
            bitcnt_ff <= SMP_BIT_FIRST;
            txbuf_ff <= '0;
            txsh_ff <= '0;
            rxsh_ff <= '0;
            rx_data_o <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            bitcnt_ff <= nxt_bitcnt;
            txsh_ff <= nxt_txsh;
            if (buf_write)
                txbuf_ff <= fifo_data;
            if (sample)
                rxsh_ff <= nxt_rxsh;
            if (done)
                rx_data_o <= rx_char;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            busy_o <= 1'h0;
            serial_clock_pin_o <= 1'h0;
            peripheral_in_line_o <= 1'h0;
            serial_clock_pin_oe_o <= 1'h0;
            peripheral_in_line_oe_o <= 1'h0;
            enable_pin_o <= 1'h0;
            enable_pin_oe_o <= 1'h0;
        end
        else
        begin
            busy_o <= nxt_shifting;
            serial_clock_pin_o <= nxt_sclk;
            peripheral_in_line_o <= nxt_pin_data;
            serial_clock_pin_oe_o <= drive;
            peripheral_in_line_oe_o <= drive;
            enable_pin_o <= nxt_select;
            enable_pin_oe_o <= active && four_pin && enable_pin_output_select_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_puc_soft_reset: assert property ($past(sys_rst_i) |-> soft_reset_ff)
        else $error("soft reset bit not set after power-up clear");
    a_soft_reset_flags: assert property (soft_reset_ff |=> tx_flag_o && !rx_flag_o
        && !overrun_error_o && !conflict_error_o && !rx_irq_enable_o && !tx_irq_enable_o)
        else $error("soft reset did not force flags");
    a_three_pin_off: assert property (!four_pin && !conflict_error_o
        |=> !conflict_error_o)
        else $error("enable pin used in three-pin mode");
    a_guard_pins: assert property (guard |=>
        !serial_clock_pin_oe_o && !peripheral_in_line_oe_o)
        else $error("pins still driven while master inactive");
    a_guard_error: assert property (guard |=> conflict_error_o)
        else $error("conflict error not set");
    a_guard_abort: assert property (guard |=> !busy_o && state_ff == SMP_ST_IDLE)
        else $error("shift not aborted by guard");
    a_start_flag: assert property ($rose(busy_o) |-> $rose(tx_flag_o))
        else $error("tx flag not set on move to shifter");
    a_write_clears: assert property (buf_write |=> !tx_flag_o)
        else $error("buffer write did not clear tx flag");
    a_done_flag: assert property (done |=> rx_flag_o && !busy_o)
        else $error("rx flag not set at end of character");
    a_seven_top: assert property ($rose(rx_flag_o) && $past(seven_bit_select_i)
        |-> !rx_data_o[SMP_MSB_8])
        else $error("seven-bit character has top bit set");
    a_read_clears: assert property (rx_read_i && !done |=> !rx_flag_o)
        else $error("read did not clear rx flag");
    a_no_idle_clock: assert property (!busy_o |-> !serial_clock_pin_o)
        else $error("serial clock toggles with no transfer");

    c_char_done: cover property (done ##1 rx_flag_o);
    c_guard_abort: cover property (busy_o ##1 guard);
    c_overrun: cover property ($rose(overrun_error_o));
    c_fifo_full: cover property ($fell(tx_ready_o));

endmodule : spi_master_port
`default_nettype wire

// ---- verification/smp_slave_model.sv ----
// Behavioural serial slave that answers the master port on the far side.
`timescale 1ns/1ps
`default_nettype none
module smp_slave_model (
    input wire logic sclk_i,
    input wire logic sclk_oe_i,
    input wire logic data_i,
    input wire logic load_i,
    input wire logic [7:0] seq_i,
    output logic data_o,
    output logic [7:0] cap_o
);
    logic [7:0] seq_ff;
    // The answer is loaded ahead of the frame so its first bit is settled before the first rise.
    // Capture on the rise, launch on the fall, only while clocked.
    always @(posedge load_i or posedge sclk_i)
        if (load_i)
            cap_o = 8'h00;
        else if (sclk_oe_i)
            cap_o = {cap_o[6:0], data_i};
    always @(posedge load_i or negedge sclk_i)
        if (load_i)
            seq_ff = seq_i;
        else if (sclk_oe_i)
            seq_ff = seq_ff << 1;
    // A released line shows the inverse so stale data never passes for a match.
    assign data_o = sclk_oe_i ? seq_ff[7] : ~seq_ff[7];
endmodule : smp_slave_model
`default_nettype wire

// ---- verification/spi_master_port_tb.sv ----
// Self-checking testbench for the SPI master port.
`timescale 1ns/1ps
`default_nettype none
module spi_master_port_tb;
    logic clk_i, sys_rst_i, soft_reset_set_i, soft_reset_clr_i, soft_reset_o;
    logic sync_mode_select_i, enable_pin_output_select_i, seven_bit_select_i, bit_order_select_i;
    logic [1:0] pin_mode_field_i;
    logic [15:0] bit_rate_divisor_i;
    logic irq_enable_wr_i, rx_irq_enable_i, tx_irq_enable_i, rx_irq_enable_o, tx_irq_enable_o;
    logic tx_valid_i, tx_ready_o, rx_read_i, rx_flag_o, tx_flag_o, busy_o;
    logic [7:0] tx_data_i, rx_data_o, rep_seq, cap, hi_len, lo_len, hcnt, lcnt;
    logic overrun_error_o, conflict_error_o, error_clear_i, rep_load, sclk_q, busy_q, sync_en;
    logic serial_clock_pin_o, serial_clock_pin_oe_o, peripheral_in_line_o;
    logic peripheral_in_line_oe_o, peripheral_out_line_i, enable_pin_i, enable_pin_o;
    logic enable_pin_oe_o;
    logic [1:0] sel_seen;
    int err_total, num_checks, done_cnt;

    spi_master_port spi_master_port_i (.clk_i, .sys_rst_i, .soft_reset_set_i, .soft_reset_clr_i,
        .soft_reset_o, .sync_mode_select_i, .pin_mode_field_i, .enable_pin_output_select_i,
        .seven_bit_select_i, .bit_order_select_i, .bit_rate_divisor_i, .irq_enable_wr_i,
        .rx_irq_enable_i, .tx_irq_enable_i, .rx_irq_enable_o, .tx_irq_enable_o, .tx_valid_i,
        .tx_data_i, .tx_ready_o, .rx_read_i, .rx_data_o, .rx_flag_o, .tx_flag_o, .overrun_error_o,
        .conflict_error_o, .error_clear_i, .busy_o, .serial_clock_pin_o, .serial_clock_pin_oe_o,
        .peripheral_in_line_o, .peripheral_in_line_oe_o, .peripheral_out_line_i, .enable_pin_i,
        .enable_pin_o, .enable_pin_oe_o);

    smp_slave_model smp_slave_model_i (.sclk_i(serial_clock_pin_o),
        .sclk_oe_i(serial_clock_pin_oe_o), .data_i(peripheral_in_line_o), .load_i(rep_load),
        .seq_i(rep_seq), .data_o(peripheral_out_line_i), .cap_o(cap));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Phase lengths of the serial clock and frames that end or abort, seen at the pins.
    always @(posedge clk_i)
    begin
        hcnt <= serial_clock_pin_o ? hcnt + 8'h01 : 8'h00;
        lcnt <= serial_clock_pin_o ? 8'h00 : lcnt + 8'h01;
        if (serial_clock_pin_o && !sclk_q)
            lo_len <= lcnt;
        if (!serial_clock_pin_o && sclk_q)
            hi_len <= hcnt;
        if (!busy_o && busy_q)
            done_cnt <= done_cnt + 1;
        sclk_q <= serial_clock_pin_o;
        busy_q <= busy_o;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
            err_total++;
        end
    endtask : chk

    function automatic logic [7:0] rev(input logic [7:0] v);
        return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
    endfunction : rev

    task automatic push(input logic [7:0] d);
        tx_valid_i = 1'b1;
        tx_data_i = d;
        tick;
        tx_valid_i = 1'b0;
        tick;
    endtask : push

    // Settings change only while the soft reset bit holds the port.
    task automatic cfg(input logic msb, input logic sev, input logic [15:0] dv,
        input logic [1:0] md, input logic stem);
        soft_reset_set_i = 1'b1;
        tick;
        soft_reset_set_i = 1'b0;
        bit_order_select_i = msb;
        seven_bit_select_i = sev;
        bit_rate_divisor_i = dv;
        pin_mode_field_i = md;
        enable_pin_output_select_i = stem;
        sync_mode_select_i = sync_en;
        tick;
        chk({tx_flag_o, rx_flag_o, overrun_error_o, conflict_error_o}, 16'h8, "soft");
        soft_reset_clr_i = 1'b1;
        tick;
        soft_reset_clr_i = 1'b0;
        for (int i = 0; i < 10 && !tx_ready_o; i++) tick;
    endtask : cfg

    task automatic xfer(input logic [7:0] d, input logic [7:0] seq);
        logic [7:0] rs;
        logic [7:0] rd;
        logic [7:0] erx;
        logic [7:0] ecap;
        int n;
        rs = rev(seq);
        rd = rev(d);
        erx = bit_order_select_i ? seq : rs;
        ecap = bit_order_select_i ? d : rd;
        if (seven_bit_select_i)
        begin
            erx = bit_order_select_i ? {1'b0, seq[7:1]} : {1'b0, rs[6:0]};
            ecap = bit_order_select_i ? {1'b0, d[6:0]} : {1'b0, rd[7:1]};
        end
        n = (bit_rate_divisor_i < 16'h0002) ? 2 : int'(bit_rate_divisor_i);
        rep_seq = seq;
        rep_load = 1'b1;
        push(d);
        rep_load = 1'b0;
        for (int i = 0; i < 10 && tx_flag_o; i++) tick;
        chk(tx_flag_o, 16'h0, "tx flag clear");
        for (int i = 0; i < 10 && !busy_o; i++) tick;
        chk({tx_flag_o, serial_clock_pin_oe_o, peripheral_in_line_oe_o}, 16'h7,
            "start");
        sel_seen = {enable_pin_oe_o, enable_pin_o};
        for (int i = 0; i < 300 && !rx_flag_o; i++) tick;
        chk(rx_data_o, erx, "rx char");
        chk(cap, ecap, "tx char");
        chk({hi_len, lo_len}, {8'((n + 1) / 2), 8'(n / 2)}, "sclk phases");
        rx_read_i = 1'b1;
        tick;
        rx_read_i = 1'b0;
        tick;
        chk(rx_flag_o, 16'h0, "rx flag read");
    endtask : xfer

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({soft_reset_o, busy_o}, 16'h2, "power-up");
        cfg(1'b0, 1'b0, 16'h0008, 2'h0, 1'b0);
        irq_enable_wr_i = 1'b1;
        tick;
        irq_enable_wr_i = 1'b0;
        tick;
        chk({rx_irq_enable_o, tx_irq_enable_o}, 16'h3, "enables set");
        soft_reset_set_i = 1'b1;
        tick;
        soft_reset_set_i = 1'b0;
        tick;
        chk({rx_irq_enable_o, tx_irq_enable_o, tx_flag_o}, 16'h1, "soft clears");
        $display("test reset done");
    endtask : t_reset

    task automatic t_formats;
        for (int k = 0; k < 4; k++)
        begin
            cfg(k[0], k[1], 16'(8 + k), 2'h0, 1'b0);
            xfer(8'ha7 ^ 8'(k), 8'h3c + 8'(k));
        end
        $display("test formats done");
    endtask : t_formats

    task automatic t_three_pin;
        for (int k = 0; k < 4; k++)
        begin
            enable_pin_i = k[0];
            cfg(1'b1, 1'b0, 16'h0008, k[1] ? 2'h3 : 2'h0, 1'b0);
            xfer(8'hc3, 8'h96);
            chk(conflict_error_o, 16'h0, "pin ignored");
        end
        $display("test three pin done");
    endtask : t_three_pin

    task automatic t_select;
        for (int k = 1; k < 3; k++)
        begin
            cfg(1'b1, 1'b0, 16'h0008, 2'(k), 1'b1);
            xfer(8'h81, 8'h42);
            chk(sel_seen, {1'b1, k == 1}, "slave select");
        end
        $display("test select done");
    endtask : t_select

    task automatic t_guard(input logic [1:0] md);
        logic lvl;
        int n;
        int snap;
        lvl = (md == 2'h1);
        enable_pin_i = !lvl;
        cfg(1'b1, 1'b0, 16'h0008, md, 1'b0);
        push(8'h5a);
        for (int i = 0; i < 10 && !busy_o; i++) tick;
        repeat (8) tick;
        enable_pin_i = lvl;
        repeat (4) tick;
        chk({busy_o, serial_clock_pin_oe_o, peripheral_in_line_oe_o}, 16'h0,
            "abort");
        chk(conflict_error_o, 16'h1, "conflict");
        snap = done_cnt;
        n = 0;
        // Fill the buffer and the queue until the port refuses more.
        while (tx_ready_o && n < 12)
        begin
            push(8'(n));
            n++;
        end
        chk(n, 16'h9, "queue full");
        chk(busy_o, 16'h0, "held inactive");
        enable_pin_i = !lvl;
        for (int i = 0; i < 10 && !busy_o; i++) tick;
        chk(busy_o, 16'h1, "resume");
        error_clear_i = 1'b1;
        tick;
        error_clear_i = 1'b0;
        // The aborted character is not resent; only the nine queued ones go out.
        for (int i = 0; i < 2000 && done_cnt - snap < 9; i++) tick;
        repeat (200) tick;
        chk(done_cnt - snap, 16'h9, "drained");
        chk({tx_ready_o, conflict_error_o}, 16'h2, "empty");
        $display("test guard done");
    endtask : t_guard

    task automatic t_overrun;
        cfg(1'b1, 1'b0, 16'h0008, 2'h0, 1'b0);
        push(8'h11);
        push(8'h22);
        for (int i = 0; i < 600 && !overrun_error_o; i++) tick;
        chk(overrun_error_o, 16'h1, "overrun");
        error_clear_i = 1'b1;
        tick;
        error_clear_i = 1'b0;
        tick;
        chk(overrun_error_o, 16'h0, "error clear");
        $display("test overrun done");
    endtask : t_overrun

    task automatic t_nosync;
        sync_en = 1'b0;
        cfg(1'b1, 1'b0, 16'h0008, 2'h0, 1'b0);
        push(8'h77);
        repeat (40) tick;
        chk(busy_o, 16'h0, "no sync");
        sync_en = 1'b1;
        $display("test nosync done");
    endtask : t_nosync

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    initial
    begin
        {soft_reset_set_i, soft_reset_clr_i, seven_bit_select_i, bit_order_select_i} = 4'h0;
        {enable_pin_output_select_i, irq_enable_wr_i, tx_valid_i, rx_read_i} = 4'h0;
        {error_clear_i, enable_pin_i, rep_load} = 3'h0;
        {rx_irq_enable_i, tx_irq_enable_i, sync_en, sync_mode_select_i, sys_rst_i} = 5'h1f;
        {pin_mode_field_i, bit_rate_divisor_i, tx_data_i, rep_seq} = 34'h0;
        repeat (6) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        tick;
        t_reset;
        t_formats;
        t_three_pin;
        t_select;
        t_guard(2'h1);
        t_guard(2'h2);
        t_overrun;
        t_nosync;
        conclude;
    end

    // The tests need some 2700 cycles; the limit leaves ample margin.
    initial
    begin
        repeat (40000) @(posedge clk_i);
        err_total++;
        conclude;
    end
endmodule : spi_master_port_tb
`default_nettype wire
